// ==== hdl/tscr_defines.svh ====
// Offsets, field positions, reset values and timing counts of the temperature sensor control block.
`ifndef TSCR_DEFINES_SVH
`define TSCR_DEFINES_SVH

`define TSCR_SEL_RESULT 2'h0
`define TSCR_SEL_CONFIG 2'h1
`define TSCR_SEL_UPPER 2'h2
`define TSCR_SEL_LOWER 2'h3

`define TSCR_CFG_SHUTDOWN_BIT 7
`define TSCR_CFG_FILTER_BIT 6
`define TSCR_CFG_ALERT_DIS_BIT 5
`define TSCR_CFG_POLARITY_BIT 4
`define TSCR_CFG_ALERT_RST_BIT 3
`define TSCR_CFG_ONE_SHOT_BIT 2
`define TSCR_CFG_RESET 8'h40
`define TSCR_CFG_STORED_MASK 8'hF0
`define TSCR_CFG_REDUCED_MASK 8'hC0

`define TSCR_RESULT_RESET 10'h000
`define TSCR_LIMIT_RESET 8'h00
`define TSCR_POINTER_RESET 8'h00

`define TSCR_CLK_PERIOD_NS 25
`define TSCR_AUTO_PERIOD_MS 800
`define TSCR_WAKE_DELAY_NS 4000
`define TSCR_CONV_TIME_NS 25000
`define TSCR_AUTO_PERIOD_CYCLES (`TSCR_AUTO_PERIOD_MS * (1000000 / `TSCR_CLK_PERIOD_NS))
`define TSCR_WAKE_CYCLES ((`TSCR_WAKE_DELAY_NS + `TSCR_CLK_PERIOD_NS - 1) / `TSCR_CLK_PERIOD_NS)
`define TSCR_CONV_CYCLES ((`TSCR_CONV_TIME_NS + `TSCR_CLK_PERIOD_NS - 1) / `TSCR_CLK_PERIOD_NS)

`endif

// ==== hdl/tscr_pkg.sv ====
// Types shared by the temperature sensor control block.
package tscr_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAKE,
        ST_CONV
    } tscr_state_e;

    typedef struct packed {
        logic shutdown_bit;
        logic line_filter_on;
        logic alert_disable;
        logic alert_polarity;
        logic alert_reset;
        logic one_shot;
        logic [1:0] factory;
    } tscr_cfg_s;

    typedef struct packed {
        logic [7:0] upper_limit;
        logic [7:0] lower_limit;
    } tscr_limits_s;

endpackage

// ==== hdl/tscr_alert.sv ====
// Limit comparator and over-limit state of the temperature sensor.
`timescale 1ns/1ps
module tscr_alert (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic conv_done_in,
    input wire logic [9:0] result_in,
    input wire tscr_pkg::tscr_limits_s limits_in,
    input wire logic clear_in,
    output logic alert_active_out
);

    // Limits are whole degrees; two zero LSBs bring them to quarter-degree units.
    wire logic signed [9:0] upper_scaled = {limits_in.upper_limit, 2'h0};
    wire logic signed [9:0] lower_scaled = {limits_in.lower_limit, 2'h0};
    wire logic signed [9:0] result_signed = result_in;
    wire logic above = conv_done_in && (result_signed > upper_scaled);
    wire logic below = conv_done_in && (result_signed < lower_scaled);
    logic active_q;

    // A new over-limit reading wins over a clear in the same cycle.
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            active_q <= 1'b0;
        else if (above)
            active_q <= 1'b1;
        else if (below || clear_in)
            active_q <= 1'b0;
    end

    assign alert_active_out = active_q;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    chk_alert_set_high: assert property (above |=> active_q)
        else $error("over-limit state not set after high reading");
    chk_alert_clear_req: assert property (clear_in && !above |=> !active_q)
        else $error("over-limit state not cleared by reset write");
    chk_alert_low_drop: assert property (below && !above |=> !active_q)
        else $error("over-limit state not cleared by low reading");

endmodule // tscr_alert

// ==== hdl/tscr_top.sv ====
// Temperature sensor control: conversion scheduler, pointer register set, over-limit output.
//
// Overview of operation
// - Automatic mode wakes the sensor every 800 ms to run one conversion.
// - Each wake-up waits 4 us power-up delay, then converts for 25 us.
// - Every finished conversion loads the result register for bus reads.
// - Writing one-shot bit as 1 starts one conversion after that write transaction.
// - One-shot holds the sample 4 us after stop; result loads 25 us later.
// - Reading above the upper limit activates the over-limit output when enabled.
// - Writing 1 to the over-limit reset bit deactivates the output.
// - Reading below the lower limit deactivates the over-limit output.
// - Reduced variant drops over-limit output and limit registers.
// - Results are 10-bit twos complement, one LSB is 0.25 degrees.
// - Full variant has four data registers selected through an address pointer.
// - Only the result register is read-only; the others accept writes.
// - First byte of every write goes to the pointer; later bytes to selected register.
// - Only the two low pointer bits select; master writes upper bits as zero (the bench also writes pointer FE).
// - Select 00 result, 01 configuration, 10 upper limit, 11 lower limit.
// - Configuration bits: shutdown 7, filter 6, alert disable 5, polarity 4, reset 3, one-shot 2.
// - Configuration resets with the filter bit set and all others clear.
// - Bit 7 set shuts down; bit 6 clear bypasses line filtering.
// - Bit 5 set disables over-limit output; bit 4 selects its active level.
// - Over-limit reset and one-shot bits act on write and read back zero.
// - One-shot while shut down powers up, converts once, then shuts down again.
`timescale 1ns/1ps
`include "tscr_defines.svh"
module tscr_top #(
    parameter bit FULL_VARIANT = 1'b1,
    parameter int unsigned AUTO_PERIOD_CYCLES = `TSCR_AUTO_PERIOD_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic xfer_start_in,
    input wire logic xfer_stop_in,
    input wire logic wr_valid_in,
    input wire logic [7:0] wr_data_in,
    input wire logic rd_req_in,
    input wire logic [9:0] temp_code_in,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    output logic power_on_out,
    output logic sample_hold_out,
    output logic conv_done_out,
    output logic line_filter_on_out,
    output logic alert_out
);

    localparam logic [9:0] WAKE_LAST = 10'(`TSCR_WAKE_CYCLES - 1);
    localparam logic [9:0] CONV_LAST = 10'(`TSCR_CONV_CYCLES - 1);
    localparam logic [31:0] PERIOD_LAST = 32'(AUTO_PERIOD_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////////
    // Register state.

    tscr_pkg::tscr_cfg_s cfg_q;
    tscr_pkg::tscr_limits_s limits_q;
    logic [7:0] pointer_q;
    logic [9:0] result_q;
    logic [9:0] sample_q;
    logic first_byte_q;
    logic second_read_q;
    logic os_written_q;
    logic os_req_q;
    tscr_pkg::tscr_state_e st_q;
    tscr_pkg::tscr_state_e st_d;
    logic [9:0] phase_q;
    logic [31:0] period_q;
    logic alert_active;

    ////////////////////////////////////////////////////////////////////////////////
    // Byte-level write decode.

    wire logic [1:0] sel = pointer_q[1:0];
    wire logic ptr_wr = wr_valid_in && first_byte_q;
    wire logic data_wr = wr_valid_in && !first_byte_q;
    wire logic cfg_wr = data_wr && (sel == `TSCR_SEL_CONFIG);
    wire logic upper_wr = data_wr && (sel == `TSCR_SEL_UPPER) && FULL_VARIANT;
    wire logic lower_wr = data_wr && (sel == `TSCR_SEL_LOWER) && FULL_VARIANT;
    wire logic alert_clear = cfg_wr && wr_data_in[`TSCR_CFG_ALERT_RST_BIT];
    wire logic one_shot_wr = cfg_wr && wr_data_in[`TSCR_CFG_ONE_SHOT_BIT];
    // Reset and one-shot bits are pulses, and factory bits are never stored.
    wire logic [7:0] cfg_mask = FULL_VARIANT ? `TSCR_CFG_STORED_MASK : `TSCR_CFG_REDUCED_MASK;
    wire logic [7:0] cfg_wdata = wr_data_in & cfg_mask;

    ////////////////////////////////////////////////////////////////////////////////
    // Conversion scheduler.

    wire logic idle = (st_q == tscr_pkg::ST_IDLE);
    wire logic auto_fire = !cfg_q.shutdown_bit && (period_q == PERIOD_LAST);
    wire logic wake_end = (st_q == tscr_pkg::ST_WAKE) && (phase_q == WAKE_LAST);
    wire logic conv_end = (st_q == tscr_pkg::ST_CONV) && (phase_q == CONV_LAST);
    wire logic launch = idle && (auto_fire || os_req_q);

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            tscr_pkg::ST_IDLE:
                if (launch)
                    st_d = tscr_pkg::ST_WAKE;
            tscr_pkg::ST_WAKE:
                if (wake_end)
                    st_d = tscr_pkg::ST_CONV;
            tscr_pkg::ST_CONV:
                if (conv_end)
                    st_d = tscr_pkg::ST_IDLE;
            default:
                st_d = tscr_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            st_q <= tscr_pkg::ST_IDLE;
            phase_q <= 10'h000;
        end
        else
        begin
            st_q <= st_d;
            phase_q <= (st_d != st_q) ? 10'h000 : phase_q + 10'h001;
        end
    end

    // The countdown only runs out of shutdown; an expiry during a one-shot is dropped.
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in || cfg_q.shutdown_bit || auto_fire)
            period_q <= 32'h00000000;
        else
            period_q <= period_q + 32'h00000001;
    end

    // A one-shot request arms at the stop that ends its write; a stop wins over launch.
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            os_written_q <= 1'b0;
            os_req_q <= 1'b0;
        end
        else
        begin
            if (xfer_stop_in)
                os_written_q <= 1'b0;
            else if (one_shot_wr)
                os_written_q <= 1'b1;
            if (xfer_stop_in && (os_written_q || one_shot_wr))
                os_req_q <= 1'b1;
            else if (launch)
                os_req_q <= 1'b0;
        end
    end

    // The front end's code is held at the end of the wake-up delay.
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            sample_q <= `TSCR_RESULT_RESET;
            result_q <= `TSCR_RESULT_RESET;
        end
        else
        begin
            if (wake_end)
                sample_q <= temp_code_in;
            if (conv_end)
                result_q <= sample_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pointer and writable registers.

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            pointer_q <= `TSCR_POINTER_RESET;
            first_byte_q <= 1'b1;
            cfg_q <= `TSCR_CFG_RESET;
            limits_q <= {`TSCR_LIMIT_RESET, `TSCR_LIMIT_RESET};
        end
        else
        begin
            if (xfer_start_in)
                first_byte_q <= 1'b1;
            else if (wr_valid_in)
                first_byte_q <= 1'b0;
            if (ptr_wr)
                pointer_q <= wr_data_in;
            if (cfg_wr)
                cfg_q <= cfg_wdata;
            if (upper_wr)
                limits_q.upper_limit <= wr_data_in;
            if (lower_wr)
                limits_q.lower_limit <= wr_data_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path. The result takes two reads: high eight bits first, then the two LSBs.

    wire logic [7:0] result_byte = second_read_q ? {result_q[1:0], alert_active, 5'h00}
                                                 : result_q[9:2];
    wire logic [7:0] upper_rd = FULL_VARIANT ? limits_q.upper_limit : 8'h00;
    wire logic [7:0] lower_rd = FULL_VARIANT ? limits_q.lower_limit : 8'h00;
    wire logic [7:0] rd_mux = (sel == `TSCR_SEL_RESULT) ? result_byte :
                              (sel == `TSCR_SEL_CONFIG) ? cfg_q :
                              (sel == `TSCR_SEL_UPPER) ? upper_rd : lower_rd;

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            second_read_q <= 1'b0;
            rd_data_out <= 8'h00;
            rd_valid_out <= 1'b0;
        end
        else
        begin
            if (xfer_start_in)
                second_read_q <= 1'b0;
            else if (rd_req_in)
                second_read_q <= !second_read_q;
            if (rd_req_in)
                rd_data_out <= rd_mux;
            rd_valid_out <= rd_req_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Over-limit monitor and pin-facing outputs.

    generate
        if (FULL_VARIANT)
        begin : g_alert
            tscr_alert u_alert (
                .clk_in(clk_in),
                .rst_n_in(rst_n_in),
                .conv_done_in(conv_end),
                .result_in(sample_q),
                .limits_in(limits_q),
                .clear_in(alert_clear),
                .alert_active_out(alert_active)
            );
        end
        else
        begin : g_no_alert
            assign alert_active = 1'b0;
        end
    endgenerate

    wire logic alert_shown = alert_active && !cfg_q.alert_disable;

    // Power stays off in idle, so a one-shot in shutdown falls back to it by itself.
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            power_on_out <= 1'b0;
            sample_hold_out <= 1'b0;
            conv_done_out <= 1'b0;
            alert_out <= 1'b1;
        end
        else
        begin
            power_on_out <= (st_d != tscr_pkg::ST_IDLE);
            sample_hold_out <= (st_d == tscr_pkg::ST_CONV);
            conv_done_out <= conv_end;
            alert_out <= alert_shown ? cfg_q.alert_polarity : !cfg_q.alert_polarity;
        end
    end

    assign line_filter_on_out = cfg_q.line_filter_on;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_wake_done;
        (st_q == tscr_pkg::ST_WAKE) && (phase_q == WAKE_LAST);
    endsequence

    sequence s_conv_begin;
        (st_q == tscr_pkg::ST_CONV) && (phase_q == 10'h000);
    endsequence

    chk_auto_period_fire: assert property (idle && auto_fire |=> st_q == tscr_pkg::ST_WAKE)
        else $error("automatic expiry did not start a wake-up");
    chk_wake_then_conv: assert property (s_wake_done |=> s_conv_begin ##1 sample_hold_out)
        else $error("wake-up delay did not lead into conversion");
    chk_result_loaded: assert property (conv_end |=> result_q == $past(sample_q) && conv_done_out)
        else $error("result register not loaded at conversion end");
    // The stop usually comes cycles after the data byte, so the armed flag is watched too.
    chk_oneshot_start: assert property (
        xfer_stop_in && (os_written_q || one_shot_wr) && idle |=> ##1 st_q == tscr_pkg::ST_WAKE)
        else $error("one-shot did not start after stop");
    chk_hold_after_wake: assert property (
        $rose(st_q == tscr_pkg::ST_WAKE) |->
        ##159 (st_q == tscr_pkg::ST_WAKE) ##1 (st_q == tscr_pkg::ST_CONV))
        else $error("sample-hold not entered after the wake-up delay");
    chk_pointer_store: assert property (ptr_wr |=> pointer_q == $past(wr_data_in))
        else $error("first write byte not stored in pointer");
    chk_pulse_bits_zero: assert property (cfg_q[3:0] == 4'h0)
        else $error("pulse or factory configuration bits read as nonzero");
    chk_shutdown_return: assert property (
        cfg_q.shutdown_bit && conv_end |=> ##1 !power_on_out)
        else $error("device did not power down after one-shot");
    chk_config_readback: assert property (
        rd_req_in && sel == `TSCR_SEL_CONFIG |=> rd_valid_out && rd_data_out == $past(cfg_q))
        else $error("configuration read returned wrong data");

endmodule // tscr_top

// ==== dv/tscr_bus_master.sv ====
// Bus master model that drives the byte-level register bus of the sensor.
`timescale 1ns/1ps
module tscr_bus_master (
    input wire logic clk_in,
    input wire logic rd_valid_in,
    input wire logic [7:0] rd_data_in,
    output logic xfer_start_out,
    output logic xfer_stop_out,
    output logic wr_valid_out,
    output logic [7:0] wr_data_out,
    output logic rd_req_out
);
    initial
    begin
        {xfer_start_out, xfer_stop_out, wr_valid_out, rd_req_out} = 4'h0;
        wr_data_out = 8'h5A;
    end
    task automatic tick();
        @(posedge clk_in);
        #1;
    endtask
    // Returns quarter degrees, so the final division by four is left to the caller.
    function automatic int quarter_deg(input logic [9:0] code);
        return code[9] ? int'(code[8:0]) - 512 : int'(code);
    endfunction
    task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data, input bit has_data);
        tick();
        xfer_start_out = 1'h1;
        tick();
        xfer_start_out = 1'h0;
        wr_valid_out = 1'h1;
        wr_data_out = ptr;
        if (has_data)
        begin
            tick();
            wr_data_out = (ptr[1:0] == 2'h1) ? (data & 8'hFC) : data;
        end
        tick();
        wr_valid_out = 1'h0;
        // A released data bus shows the inverse so a stale byte never looks fresh.
        wr_data_out = ~wr_data_out;
        xfer_stop_out = 1'h1;
        tick();
        xfer_stop_out = 1'h0;
    endtask
    task automatic read_bytes(input int n, output logic [7:0] b0, output logic [7:0] b1,
        output bit ok);
        ok = 1'b1;
        b1 = 8'h00;
        tick();
        xfer_start_out = 1'h1;
        tick();
        xfer_start_out = 1'h0;
        for (int k = 0; k < n; k++)
        begin
            rd_req_out = 1'h1;
            tick();
            rd_req_out = 1'h0;
            if (rd_valid_in !== 1'h1)
                ok = 1'b0;
            if (k == 0)
                b0 = rd_data_in;
            else
                b1 = rd_data_in;
            tick();
        end
        xfer_stop_out = 1'h1;
        tick();
        xfer_stop_out = 1'h0;
    endtask
endmodule // tscr_bus_master

// ==== dv/tscr_top_bench.sv ====
// Self-checking testbench of the temperature sensor control block.
`timescale 1ns/1ps
module tscr_top_bench;
    localparam int unsigned PERIOD = 2000;
    logic clk_in = 1'h0;
    logic rst_n_in = 1'h0;
    logic [9:0] temp_code = 10'h000;
    logic st, sp, wv, rq, rv, pwr, sh, done, flt, alert, rv2, ok_b;
    logic [7:0] wd, rd, rd2, b0, b1;
    logic [7:0] cfg_m = 8'h40;
    logic [7:0] up_m = 8'h00;
    logic [7:0] lo_m = 8'h00;
    logic [9:0] res_m = 10'h000;
    logic act_m = 1'h0;
    int failures = 0;
    int tests_run = 0;
    int n;
    logic [9:0] codes [7] = '{10'h1F4, 10'h324, 10'h065, 10'h064, 10'h028, 10'h000, 10'h1F4};
    always #12.5 clk_in = ~clk_in;
    tscr_top #(.FULL_VARIANT(1'h1), .AUTO_PERIOD_CYCLES(PERIOD)) u_dut (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .xfer_start_in(st), .xfer_stop_in(sp), .wr_valid_in(wv),
        .wr_data_in(wd), .rd_req_in(rq), .temp_code_in(temp_code), .rd_data_out(rd),
        .rd_valid_out(rv), .power_on_out(pwr), .sample_hold_out(sh), .conv_done_out(done),
        .line_filter_on_out(flt), .alert_out(alert));
    tscr_top #(.FULL_VARIANT(1'h0), .AUTO_PERIOD_CYCLES(PERIOD)) u_dut_red (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .xfer_start_in(st), .xfer_stop_in(sp), .wr_valid_in(wv),
        .wr_data_in(wd), .rd_req_in(rq), .temp_code_in(temp_code), .rd_data_out(rd2),
        .rd_valid_out(rv2), .power_on_out(), .sample_hold_out(), .conv_done_out(),
        .line_filter_on_out(), .alert_out());
    tscr_bus_master u_master (.clk_in(clk_in), .rd_valid_in(rv), .rd_data_in(rd),
        .xfer_start_out(st), .xfer_stop_out(sp), .wr_valid_out(wv), .wr_data_out(wd),
        .rd_req_out(rq));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic bad(input string what);
        failures++;
        $display("ERROR %0t: %s", $time, what);
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
            bad($sformatf("byte %h, expected %h", got, exp));
    endtask
    task automatic chk1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp)
            bad($sformatf("bit %b, expected %b", got, exp));
    endtask
    task automatic chk_n(input int got, input int exp);
        tests_run++;
        if (got != exp)
            bad($sformatf("count %0d, expected %0d", got, exp));
    endtask
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    function automatic int sx(input logic [9:0] c);
        return c[9] ? int'(c) - 1024 : int'(c);
    endfunction
    function automatic logic sig(input int w);
        return (w == 0) ? pwr : (w == 1) ? sh : done;
    endfunction
    // Bounded wait; a run that hangs here ends with the closing report.
    task automatic wait_on(input int w, input int bound, output int cnt);
        cnt = 0;
        while (sig(w) !== 1'h1 && cnt < bound)
        begin
            u_master.tick();
            cnt++;
        end
        if (cnt >= bound)
        begin
            bad("wait timed out");
            finish_test();
        end
    endtask
    task automatic write_cfg(input logic [7:0] v);
        u_master.write_reg(8'h01, v, 1'b1);
        cfg_m = v & 8'hF0;
        if (v[3])
            act_m = 1'h0;
        u_master.tick();
        u_master.tick();
        chk1(alert, (act_m && !cfg_m[5]) ? cfg_m[4] : !cfg_m[4]);
    endtask
    task automatic read_sel(input logic [7:0] ptr, input logic [7:0] exp);
        u_master.write_reg(ptr, 8'h00, 1'b0);
        u_master.read_bytes(1, b0, b1, ok_b);
        chk1(ok_b, 1'h1);
        chk8(b0, exp);
    endtask
    task automatic one_shot(input logic [9:0] code);
        temp_code = code;
        // Counting starts right after the stop, so both delays are measured from their edges.
        u_master.write_reg(8'h01, cfg_m | 8'h04, 1'b1);
        wait_on(0, 8, n);
        chk_n(n, 1);
        chk1(alert, (act_m && !cfg_m[5]) ? cfg_m[4] : !cfg_m[4]);
        wait_on(1, 400, n);
        chk_n(n, 160);
        wait_on(2, 1200, n);
        chk_n(n, 1000);
        res_m = code;
        if (sx(code) > sx({up_m, 2'h0}))
            act_m = 1'h1;
        else if (sx(code) < sx({lo_m, 2'h0}))
            act_m = 1'h0;
        u_master.tick();
        chk1(pwr, 1'h0);
        u_master.tick();
        chk1(alert, (act_m && !cfg_m[5]) ? cfg_m[4] : !cfg_m[4]);
        u_master.write_reg(8'h00, 8'h00, 1'b0);
        u_master.read_bytes(2, b0, b1, ok_b);
        chk1(ok_b, 1'h1);
        chk8(b0, res_m[9:2]);
        chk8(b1, {res_m[1:0], act_m, 5'h00});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'hB4A4));
        repeat (6) @(posedge clk_in);
        #1 rst_n_in = 1'h1;
        read_sel(8'h01, 8'h40);
        chk1(flt, 1'h1);
        chk1(alert, 1'h1);
        write_cfg(8'h83);
        read_sel(8'h01, 8'h80);
        chk1(flt, 1'h0);
        $display("reset and config test done");
        up_m = 8'($urandom());
        lo_m = 8'($urandom());
        u_master.write_reg(8'h02, up_m, 1'b1);
        u_master.write_reg(8'h03, lo_m, 1'b1);
        u_master.write_reg(8'h00, 8'h5A, 1'b1);
        read_sel(8'h03, lo_m);
        chk8(rd2, 8'h00);
        read_sel(8'hFE, up_m);
        u_master.read_bytes(1, b0, b1, ok_b);
        chk8(b0, up_m);
        read_sel(8'h00, 8'h00);
        $display("register test done");
        up_m = 8'h19;
        lo_m = 8'h0A;
        u_master.write_reg(8'h02, up_m, 1'b1);
        u_master.write_reg(8'h03, lo_m, 1'b1);
        write_cfg(8'h90);
        codes[5] = 10'($urandom());
        for (int i = 0; i < 7; i++)
        begin
            one_shot(codes[i]);
            if (i < 2)
                chk_n(u_master.quarter_deg({b0, b1[7:6]}), i == 0 ? 500 : -220);
            if (i == 2)
                write_cfg(8'h98);
            if (i == 4)
                write_cfg(8'hB0);
            if (i == 5)
                write_cfg(8'h80);
        end
        $display("conversion and limit test done");
        temp_code = 10'($urandom());
        write_cfg(8'h10);
        // The first automatic result needs a full period plus wake-up and conversion.
        wait_on(2, 3400, n);
        u_master.tick();
        wait_on(2, 2200, n);
        chk_n(n + 1, PERIOD);
        u_master.write_reg(8'h00, 8'h00, 1'b0);
        u_master.read_bytes(2, b0, b1, ok_b);
        chk8(b0, temp_code[9:2]);
        $display("automatic test done");
        finish_test();
    end
endmodule // tscr_top_bench
